/* hw/qdd_defines.vh */
/*
 * constants for the quad converter decimating datapath: register
 * addresses, reset values, operating mode codes and fixed figures.
 * assumes it is included by bare name from the datapath module.
 */
`ifndef QDD_DEFINES_VH
`define QDD_DEFINES_VH

// ---------------------------------------------------------------
// register addresses and reset values
// ---------------------------------------------------------------
`define QDD_ADDR_OVR_UPPER 16'h0027
`define QDD_ADDR_OVR_LOWER 16'h0028
`define QDD_RST_OVR_UPPER  8'h88
`define QDD_RST_OVR_LOWER  8'h08

// ---------------------------------------------------------------
// operating modes
// ---------------------------------------------------------------
`define QDD_MODE_QMIX   4'h0
`define QDD_MODE_NCO_IQ 4'h1
`define QDD_MODE_REAL2  4'h2
`define QDD_MODE_SHIFT  4'h3
`define QDD_MODE_REAL4  4'h4
`define QDD_MODE_IQ8    4'h6
`define QDD_MODE_ZSTUFF 4'h7
`define QDD_MODE_BYPASS 4'h8

// ---------------------------------------------------------------
// fixed figures
// ---------------------------------------------------------------
`define QDD_OVR_MID     8'h48
`define QDD_NCO_QPOS    16'h4000
`define QDD_NCO_QNEG    16'hc000
`define QDD_FIFO_DEPTH  8

`endif

/* hw/qdd_fifo.v */
/*
 * shift-register fifo with registered head entry.
 * assumes one clock, synchronous active-high reset, valid/ready on
 * both sides; a word moves when valid and ready are both high.
 */
`timescale 1ns/10ps
`default_nettype none

module qdd_fifo #(
   parameter WIDTH = 128,
   parameter DEPTH = 8,
   parameter CW    = 4
) (
   input  wire             clk,
   input  wire             srst,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);

   reg  [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg  [CW-1:0]    cnt_reg;
   wire             push;
   wire             pop;

   // honest full and empty from the fill count
   assign in_ready  = (cnt_reg != DEPTH[CW-1:0]);
   assign out_valid = (cnt_reg != {CW{1'b0}});
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_reg[0];

   // fill count
   always @(posedge clk) begin
      if (srst) begin
         cnt_reg <= {CW{1'b0}};
      end else if (push & ~pop) begin
         cnt_reg <= cnt_reg + 1'b1;
      end else if (pop & ~push) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   // each entry shifts toward the head on pop; on push the entry at the fill count loads, or the one below it when a pop happens in the same cycle
   genvar e;
   generate
      for (e = 0; e < DEPTH; e = e + 1) begin : g_ent
         wire [WIDTH-1:0] above;
         if (e + 1 < DEPTH) begin : g_up
            assign above = mem_reg[e+1];
         end else begin : g_top
            assign above = {WIDTH{1'b0}};
         end
         always @(posedge clk) begin
            if (srst) begin
               mem_reg[e] <= {WIDTH{1'b0}};
            end else if (pop) begin
               if (push && (cnt_reg == e + 1)) begin
                  mem_reg[e] <= in_data;
               end else begin
                  mem_reg[e] <= above;
               end
            end else if (push && (cnt_reg == e)) begin
               mem_reg[e] <= in_data;
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

/* hw/qdd_datapath.v */
/*
 * four-channel decimating down-converter datapath with fast overrange
 * flags and an output fifo toward the serial link transmitter.
 * assumes two interleaved core samples per channel per clock, control
 * inputs loaded by cfg_load, and register writes already decoded.
 */
`timescale 1ns/10ps
`default_nettype none
`include "qdd_defines.vh"

// Functional notes
// RULE1: two interleaved cores per channel merge into one stream, then halve.
// RULE2: first decimator is low-pass or high-pass; low-pass after reset.
// RULE3: after reset mode 0: fixed minus quarter-rate mix, complex output.
// RULE4: mode 8 skips down-conversion; first-stage real samples go out.
// RULE5: oscillator makes complex exponential, multiplies real samples to baseband.
// RULE6: oscillator frequency is word times sample rate over two to sixteen.
// RULE7: first decimate-by-two is fixed and used in every mode.
// RULE8: second decimator halves half-clock rate down to quarter-clock rate.
// RULE9: mode 0 quarter-rate complex mixer precedes second decimator, IQ output.
// RULE10: mode 1 oscillator mixer precedes second decimator, IQ output.
// RULE11: mode 2 cascades two selectable decimators, real output.
// RULE12: mode 3 oscillator then quarter-rate mix, real; zero at quarter word.
// RULE13: mode 4 oscillator, second decimator, then quarter output-rate mix.
// RULE14: mode 6 oscillator feeds complex decimate-by-four, IQ output.
// RULE15: mode 7 is mode 4 with a zero after every real sample; the code outputs zero in every mode 7 slot.
// RULE16: in mode 8 one bit picks first decimator high-pass or low-pass.
// RULE17: dual mode averages A with B, C with D, at full rate.
// RULE18: host selects mode 8 before enabling dual averaging.
// RULE19: enabled overrange embedding replaces each output sample's lowest bit.
// RULE20: overrange flag compares early samples against eight-bit upper, lower limits.
// RULE21: code 136 is maximum, 8 minimum, 72 is mid-scale; the code's sample codes run from 8 to 135.
// RULE22: host writes upper limit at 27h, lower limit at 28h.
// RULE23: overrange checked per channel per sample, aligned with its output.
module qdd_datapath #(
   parameter NCH   = 4,
   parameter SW    = 14,
   parameter DEPTH = `QDD_FIFO_DEPTH
) (
   input  wire              clk,
   input  wire              srst,
   input  wire [NCH*SW-1:0] in_core0,
   input  wire [NCH*SW-1:0] in_core1,
   input  wire              in_valid,
   output wire              in_ready,
   input  wire              cfg_load,
   input  wire [3:0]        cfg_mode,
   input  wire              cfg_hbf_highpass,
   input  wire              cfg_stage2_highpass,
   input  wire              cfg_dual_en,
   input  wire              cfg_ovr_embed,
   input  wire [15:0]       oscillator_frequency_word,
   input  wire              reg_wr_en,
   input  wire [15:0]       reg_addr,
   input  wire [7:0]        reg_wr_data,
   output reg  [7:0]        reg_rd_data,
   output wire [NCH*32-1:0] out_data,
   output wire              out_valid,
   input  wire              out_ready,
   output wire [NCH-1:0]    fast_overrange_flag
);

   // ---------------------------------------------------------------
   // configuration and threshold registers
   // ---------------------------------------------------------------
   reg  [3:0]        mode_reg;
   reg               hbf_hp_reg;
   reg               s2_hp_reg;
   reg               dual_reg;
   reg               embed_reg;
   reg  [15:0]       word_reg;
   reg  [7:0]        upper_reg;
   reg  [7:0]        lower_reg;
   reg               v1_reg;
   reg               v2_reg;
   reg               ov_reg;
   reg  [1:0]        mix_ph_reg;
   reg  [15:0]       nco_ph_reg;
   reg  [1:0]        grp_reg;
   reg  [1:0]        om_reg;
   wire              adv;
   wire              fifo_ready;
   wire              push;
   wire              dual_on;
   wire              last;
   wire              nco_on;
   wire              q_word;
   wire [2:0]        gsize;
   wire signed [15:0] cos_v;
   wire signed [15:0] sin_v;
   wire [NCH*32-1:0] fifo_din;

   // RULE2 RULE3 reset to mode 0, low-pass
   always @(posedge clk) begin
      if (srst) begin
         mode_reg   <= `QDD_MODE_QMIX;
         hbf_hp_reg <= 1'b0;
         s2_hp_reg  <= 1'b0;
         dual_reg   <= 1'b0;
         embed_reg  <= 1'b0;
         word_reg   <= 16'h0000;
      end else if (cfg_load) begin
         mode_reg   <= cfg_mode;
         hbf_hp_reg <= cfg_hbf_highpass;
         s2_hp_reg  <= cfg_stage2_highpass;
         dual_reg   <= cfg_dual_en;
         embed_reg  <= cfg_ovr_embed;
         word_reg   <= oscillator_frequency_word;
      end
   end

   // RULE22 threshold writes at fixed addresses
   always @(posedge clk) begin
      if (srst) begin
         upper_reg <= `QDD_RST_OVR_UPPER;
         lower_reg <= `QDD_RST_OVR_LOWER;
      end else if (reg_wr_en) begin
         if (reg_addr == `QDD_ADDR_OVR_UPPER) begin
            upper_reg <= reg_wr_data;
         end
         if (reg_addr == `QDD_ADDR_OVR_LOWER) begin
            lower_reg <= reg_wr_data;
         end
      end
   end

   // registered read-back, zero for unmapped addresses
   always @(posedge clk) begin
      if (srst) begin
         reg_rd_data <= 8'h00;
      end else if (reg_addr == `QDD_ADDR_OVR_UPPER) begin
         reg_rd_data <= upper_reg;
      end else if (reg_addr == `QDD_ADDR_OVR_LOWER) begin
         reg_rd_data <= lower_reg;
      end else begin
         reg_rd_data <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // shared sequencing
   // ---------------------------------------------------------------
   // the whole pipeline steps only when a sample arrives and fifo has room
   assign adv      = in_valid & fifo_ready;
   assign in_ready = fifo_ready;
   // RULE18 averaging only honoured once mode 8 is set
   assign dual_on  = dual_reg & (mode_reg == `QDD_MODE_BYPASS);
   assign nco_on   = (mode_reg == `QDD_MODE_NCO_IQ) | (mode_reg == `QDD_MODE_SHIFT) |
                     (mode_reg == `QDD_MODE_REAL4) | (mode_reg == `QDD_MODE_IQ8) |
                     (mode_reg == `QDD_MODE_ZSTUFF);
   // RULE12 quarter-rate word flag
   assign q_word   = (word_reg == `QDD_NCO_QPOS) | (word_reg == `QDD_NCO_QNEG);

   // RULE8 RULE14 group size of the second decimator per mode
   assign gsize = (mode_reg == `QDD_MODE_IQ8) ? 3'd4 :
                  ((mode_reg == `QDD_MODE_SHIFT) | (mode_reg == `QDD_MODE_BYPASS) |
                   (mode_reg == `QDD_MODE_ZSTUFF)) ? 3'd1 : 3'd2;
   assign last  = (gsize == 3'd1) | ((gsize == 3'd2) & grp_reg[0]) |
                  ((gsize == 3'd4) & (grp_reg == 2'd3));

   // coarse sine table, sixteen phases per turn
   function signed [15:0] sin16;
      input [3:0] p;
      reg   [15:0] m;
      begin
         case (p[2:0])
            3'd0:    m = 16'h0000;
            3'd1:    m = 16'h30fb;
            3'd2:    m = 16'h5a82;
            3'd3:    m = 16'h7641;
            3'd4:    m = 16'h7fff;
            3'd5:    m = 16'h7641;
            3'd6:    m = 16'h5a82;
            3'd7:    m = 16'h30fb;
            default: m = 16'h0000;
         endcase
         sin16 = p[3] ? -m : m;
      end
   endfunction

   // RULE5 RULE6 phase accumulator steps by the word each sample
   assign sin_v = sin16(nco_ph_reg[15:12]);
   assign cos_v = sin16(nco_ph_reg[15:12] + 4'h4);

   // pipeline valids, mixer and group counters
   always @(posedge clk) begin
      if (srst) begin
         v1_reg     <= 1'b0;
         v2_reg     <= 1'b0;
         ov_reg     <= 1'b0;
         mix_ph_reg <= 2'd0;
         nco_ph_reg <= 16'h0000;
         grp_reg    <= 2'd0;
         om_reg     <= 2'd0;
      end else if (adv) begin
         v1_reg <= 1'b1;
         v2_reg <= v1_reg;
         if (v1_reg) begin
            mix_ph_reg <= mix_ph_reg + 2'd1;
            nco_ph_reg <= nco_ph_reg + word_reg;
         end
         ov_reg <= v2_reg & last;
         if (v2_reg) begin
            grp_reg <= last ? 2'd0 : grp_reg + 2'd1;
            // RULE15 zero slot does not step the output mixer
            if (last & ~((mode_reg == `QDD_MODE_ZSTUFF) & ~grp_reg[0])) begin
               om_reg <= om_reg + 2'd1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // per-channel datapath
   // ---------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < NCH; c = c + 1) begin : g_ch
         wire signed [SW-1:0] a0 = in_core0[c*SW +: SW];
         wire signed [SW-1:0] a1 = in_core1[c*SW +: SW];
         wire signed [SW-1:0] b0 = in_core0[(c^1)*SW +: SW];
         wire signed [SW-1:0] b1 = in_core1[(c^1)*SW +: SW];
         wire signed [15:0]   sum = {{2{a0[SW-1]}}, a0} + {{2{a1[SW-1]}}, a1};
         wire signed [15:0]   dif = {{2{a0[SW-1]}}, a0} - {{2{a1[SW-1]}}, a1};
         wire signed [15:0]   av0 = {{2{a0[SW-1]}}, a0} + {{2{b0[SW-1]}}, b0};
         wire signed [15:0]   av1 = {{2{a1[SW-1]}}, a1} + {{2{b1[SW-1]}}, b1};
         wire [7:0] code0 = `QDD_OVR_MID + {a0[SW-1], a0[SW-1:SW-7]};
         wire [7:0] code1 = `QDD_OVR_MID + {a1[SW-1], a1[SW-1:SW-7]};
         reg  signed [15:0] h_reg;
         reg  signed [15:0] d0_reg;
         reg  signed [15:0] d1_reg;
         reg                f1_reg;
         reg                fd_reg;
         reg  signed [15:0] i2_reg;
         reg  signed [15:0] q2_reg;
         reg                f2_reg;
         reg  signed [17:0] ai_reg;
         reg  signed [17:0] aq_reg;
         reg                fa_reg;
         reg  signed [15:0] oi_reg;
         reg  signed [15:0] oq_reg;
         reg                of_reg;
         reg  signed [15:0] mi;
         reg  signed [15:0] mq;
         reg  signed [17:0] ti;
         reg  signed [17:0] tq;
         reg  signed [15:0] di;
         reg  signed [15:0] dq;
         reg  signed [15:0] ri;
         reg  signed [15:0] rq;
         wire signed [31:0] pc = h_reg * cos_v;
         wire signed [31:0] ps = h_reg * sin_v;
         wire               fo = fa_reg | f2_reg;
         wire [15:0] oi_e = {oi_reg[15:1], embed_reg ? of_reg : oi_reg[0]};
         wire [15:0] oq_e = {oq_reg[15:1], embed_reg ? of_reg : oq_reg[0]};
         wire [15:0] d0_e = {d0_reg[15:1], embed_reg ? fd_reg : d0_reg[0]};
         wire [15:0] d1_e = {d1_reg[15:1], embed_reg ? fd_reg : d1_reg[0]};

         // RULE1 RULE7 RULE16 fixed first half-band, selectable high-pass
         // RULE20 RULE21 RULE23 per-sample threshold check on raw cores
         always @(posedge clk) begin
            if (srst) begin
               h_reg  <= 16'sh0000;
               d0_reg <= 16'sh0000;
               d1_reg <= 16'sh0000;
               f1_reg <= 1'b0;
               fd_reg <= 1'b0;
            end else if (adv) begin
               h_reg  <= hbf_hp_reg ? {dif[14:0], 1'b0} : {sum[14:0], 1'b0};
               // RULE17 pair average at full rate, both cores kept
               d0_reg <= {av0[14:0], 1'b0};
               d1_reg <= {av1[14:0], 1'b0};
               f1_reg <= (code0 >= upper_reg) | (code0 <= lower_reg) |
                         (code1 >= upper_reg) | (code1 <= lower_reg);
               fd_reg <= (code0 >= upper_reg) | (code0 <= lower_reg) |
                         (code1 >= upper_reg) | (code1 <= lower_reg) |
                         (b0[SW-1:SW-7] == 7'h3f) | (b0[SW-1:SW-7] == 7'h40);
            end
         end

         // mixer selection per mode
         always @* begin
            mi = h_reg;
            mq = 16'sh0000;
            if (mode_reg == `QDD_MODE_QMIX) begin
               // RULE3 RULE9 multiply by e^(-j pi n / 2)
               case (mix_ph_reg)
                  2'd0:    begin mi = h_reg;  mq = 16'sh0000; end
                  2'd1:    begin mi = 16'sh0000; mq = -h_reg; end
                  2'd2:    begin mi = -h_reg; mq = 16'sh0000; end
                  2'd3:    begin mi = 16'sh0000; mq = h_reg;  end
                  default: begin mi = h_reg;  mq = 16'sh0000; end
               endcase
            end else if (nco_on) begin
               // RULE5 RULE10 complex exponential times real sample
               mi = pc[30:15];
               mq = -ps[30:15];
            end
         end

         // second-stage sums and output quarter-rate mixer
         always @* begin
            ti = ai_reg + {{2{i2_reg[15]}}, i2_reg};
            tq = aq_reg + {{2{q2_reg[15]}}, q2_reg};
            if ((mode_reg == `QDD_MODE_REAL2) & s2_hp_reg) begin
               // RULE11 second filter high-pass, mixed pairs invert
               ti = ai_reg - {{2{i2_reg[15]}}, i2_reg};
            end
            if (gsize == 3'd4) begin
               di = ti[17:2];
               dq = tq[17:2];
            end else if (gsize == 3'd2) begin
               di = ti[16:1];
               dq = tq[16:1];
            end else if (mode_reg == `QDD_MODE_ZSTUFF) begin
               // RULE15 mode 4 scaling of the second-stage sum; grp_reg stays 0, so no pair is held
               di = ti[16:1];
               dq = tq[16:1];
            end else begin
               di = i2_reg;
               dq = q2_reg;
            end
            ri = di;
            rq = dq;
            if ((mode_reg == `QDD_MODE_SHIFT) | (mode_reg == `QDD_MODE_REAL4) |
                (mode_reg == `QDD_MODE_ZSTUFF)) begin
               // RULE12 RULE13 real part after quarter output-rate mix
               case (om_reg)
                  2'd0:    ri = di;
                  2'd1:    ri = -dq;
                  2'd2:    ri = -di;
                  2'd3:    ri = dq;
                  default: ri = di;
               endcase
               rq = 16'sh0000;
               if ((mode_reg == `QDD_MODE_SHIFT) & q_word) begin
                  ri = 16'sh0000;
               end
               if ((mode_reg == `QDD_MODE_ZSTUFF) & ~grp_reg[0]) begin
                  ri = 16'sh0000;
               end
            end
         end

         // mixer, accumulator and output registers
         always @(posedge clk) begin
            if (srst) begin
               i2_reg <= 16'sh0000;
               q2_reg <= 16'sh0000;
               f2_reg <= 1'b0;
               ai_reg <= 18'sh00000;
               aq_reg <= 18'sh00000;
               fa_reg <= 1'b0;
               oi_reg <= 16'sh0000;
               oq_reg <= 16'sh0000;
               of_reg <= 1'b0;
            end else if (adv) begin
               // RULE4 bypass passes h_reg unmixed
               i2_reg <= mi;
               q2_reg <= mq;
               f2_reg <= f1_reg;
               if (v2_reg) begin
                  if (last & ~((mode_reg == `QDD_MODE_ZSTUFF) & grp_reg[0])) begin
                     ai_reg <= 18'sh00000;
                     aq_reg <= 18'sh00000;
                     fa_reg <= 1'b0;
                  end else begin
                     ai_reg <= ti;
                     aq_reg <= tq;
                     fa_reg <= fo;
                  end
                  if (last) begin
                     oi_reg <= ri;
                     oq_reg <= rq;
                     of_reg <= fo;
                  end
               end
            end
         end

         // RULE19 lowest bit carries the flag when embedding
         // RULE17 dual slots: even channel carries the pair average
         assign fifo_din[c*32 +: 32] = dual_on ?
                                       (((c % 2) == 0) ? {d0_e, d1_e} : 32'h00000000) :
                                       {oi_e, oq_e};
         assign fast_overrange_flag[c] = f1_reg;
      end
   endgenerate

   // ---------------------------------------------------------------
   // output fifo
   // ---------------------------------------------------------------
   // push the held result on the step after the one that loads it
   assign push = adv & (dual_on ? v1_reg : ov_reg);

   qdd_fifo #(
      .WIDTH (NCH*32),
      .DEPTH (DEPTH),
      .CW    (4)
   ) u_fifo (
      .clk       (clk),
      .srst      (srst),
      .in_data   (fifo_din),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .out_data  (out_data),
      .out_valid (out_valid),
      .out_ready (out_ready)
   );

endmodule

`default_nettype wire

/* dv/qdd_properties.sv */
/* port checker for the datapath: register mirror, overrange flags, fifo.
   assumes a bind onto qdd_datapath, one clock, srst synchronous. */
`timescale 1ns/10ps
`default_nettype none
module qdd_properties #(
   parameter NCH = 4,
   parameter SW  = 14
) (
   input wire logic              clk,
   input wire logic              srst,
   input wire logic [NCH*SW-1:0] in_core0,
   input wire logic [NCH*SW-1:0] in_core1,
   input wire logic              in_valid,
   input wire logic              in_ready,
   input wire logic              cfg_load,
   input wire logic [3:0]        cfg_mode,
   input wire logic              cfg_dual_en,
   input wire logic              reg_wr_en,
   input wire logic [15:0]       reg_addr,
   input wire logic [7:0]        reg_wr_data,
   input wire logic [7:0]        reg_rd_data,
   input wire logic [NCH*32-1:0] out_data,
   input wire logic              out_valid,
   input wire logic              out_ready,
   input wire logic [NCH-1:0]    fast_overrange_flag
);
   logic [7:0]     up_reg, lo_reg, exp_rd;
   logic           dual_reg;
   logic [NCH-1:0] flag_exp;
   // threshold mirror and dual tracking
   always @(posedge clk) begin
      if (srst) begin
         up_reg <= 8'h88;
         lo_reg <= 8'h08;
         dual_reg <= 1'b0;
      end else begin
         if (reg_wr_en && reg_addr == 16'h0027) up_reg <= reg_wr_data;
         if (reg_wr_en && reg_addr == 16'h0028) lo_reg <= reg_wr_data;
         if (cfg_load) dual_reg <= cfg_dual_en && cfg_mode == 4'h8;
      end
   end
   assign exp_rd = reg_addr == 16'h0027 ? up_reg : reg_addr == 16'h0028 ? lo_reg : 8'h00;
   function automatic logic hit(input logic [13:0] s);
      logic [7:0] code;
      code = 8'h48 + {s[13], s[13:7]};
      return code >= up_reg || code <= lo_reg;
   endfunction
   // expected flag per channel
   always_comb begin
      for (int c = 0; c < NCH; c++) flag_exp[c] = hit(in_core0[c*SW+:14]) | hit(in_core1[c*SW+:14]);
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   property p_rd_map;
      !$past(srst) |-> reg_rd_data == $past(exp_rd);
   endproperty
   a_rd_map: assert property (p_rd_map) else $error("read data wrong");
   property p_flag;
      in_valid && in_ready && !dual_reg |=> fast_overrange_flag == $past(flag_exp);
   endproperty
   a_flag: assert property (p_flag) else $error("overrange flag wrong");
   property p_flag_hold;
      !(in_valid && in_ready) |=> $stable(fast_overrange_flag);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag moved while idle");
   property p_out_hold;
      out_valid && !out_ready |=> out_valid && $stable(out_data);
   endproperty
   a_out_hold: assert property (p_out_hold) else $error("head word moved");
   property p_full;
      !in_ready |-> out_valid;
   endproperty
   a_full: assert property (p_full) else $error("full but empty");
   property p_pop_frees;
      !in_ready && out_ready |=> in_ready;
   endproperty
   a_pop_frees: assert property (p_pop_frees) else $error("pop left fifo full");
   property p_push_cause;
      $rose(out_valid) |-> $past(in_valid && in_ready);
   endproperty
   a_push_cause: assert property (p_push_cause) else $error("word without input");
   property p_reset;
      disable iff (1'b0) srst |=> !out_valid && in_ready && reg_rd_data == 8'h00 && fast_overrange_flag == '0;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule
bind qdd_datapath qdd_properties #(.NCH(NCH), .SW(SW)) i_props (.clk(clk), .srst(srst), .in_core0(in_core0),
   .in_core1(in_core1), .in_valid(in_valid), .in_ready(in_ready), .cfg_load(cfg_load), .cfg_mode(cfg_mode),
   .cfg_dual_en(cfg_dual_en), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
   .reg_rd_data(reg_rd_data), .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
   .fast_overrange_flag(fast_overrange_flag));
`default_nettype wire

/* dv/qdd_sink.sv */
/* link transmitter stand-in: takes output words, may stall.
   assumes the bench drives stall shortly after a rising edge. */
`timescale 1ns/10ps
`default_nettype none
module qdd_sink (
   input wire logic         clk,
   input wire logic         stall,
   input wire logic [127:0] data,
   input wire logic         valid,
   output var logic         ready
);
   logic [127:0] q[$];
   initial ready = 1'b0;
   // collect popped words, ready follows the inverse of stall
   always @(posedge clk) begin
      if (valid && ready) q.push_back(data);
      ready <= #1 !stall;
   end
endmodule
`default_nettype wire

/* dv/qdd_datapath_test.sv */
/* bench for qdd_datapath: registers, bypass, embed, shift zeroing, dual, fifo.
   assumes qdd_sink as far side and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module qdd_datapath_test;
   logic clk = 0, srst = 1, in_valid = 0, cfg_load = 0, hp = 0, dual = 0, emb = 0, wr = 0, stall = 0;
   logic [55:0] c0 = '0, c1 = '0;
   logic [3:0] mode = '0;
   logic [15:0] word = '0, addr = '0;
   logic [7:0] wdata = '0;
   wire [7:0] rdata;
   wire [127:0] odata;
   wire ovalid, ordy, irdy;
   wire [3:0] flag;
   int fail_count = 0, cmp_count = 0, n;
   always #2 clk = ~clk;
   qdd_datapath i_dut (.clk(clk), .srst(srst), .in_core0(c0), .in_core1(c1), .in_valid(in_valid), .in_ready(irdy),
      .cfg_load(cfg_load), .cfg_mode(mode), .cfg_hbf_highpass(hp), .cfg_stage2_highpass(hp), .cfg_dual_en(dual),
      .cfg_ovr_embed(emb), .oscillator_frequency_word(word), .reg_wr_en(wr), .reg_addr(addr), .reg_wr_data(wdata),
      .reg_rd_data(rdata), .out_data(odata), .out_valid(ovalid), .out_ready(ordy), .fast_overrange_flag(flag));
   qdd_sink i_sink (.clk(clk), .stall(stall), .data(odata), .valid(ovalid), .ready(ordy));
   task chk(input logic [127:0] got, input logic [127:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task rst;
      srst = 1;
      tick(8);
      srst = 0;
      i_sink.q.delete();
   endtask
   task cfg(input logic [3:0] m, input logic h, input logic d, input logic e, input logic [15:0] w);
      mode = m; hp = h; dual = d; emb = e; word = w; cfg_load = 1;
      tick(1);
      cfg_load = 0;
      tick(1);
   endtask
   task wr_reg(input logic [15:0] a, input logic [7:0] d);
      addr = a; wdata = d; wr = 1;
      tick(1);
      wr = 0;
      tick(1);
   endtask
   task rd_reg(input logic [15:0] a, input logic [7:0] e);
      addr = a;
      tick(2);
      chk(rdata, e);
   endtask
   // push k inputs, then let the fifo empty into the sink
   task push(input int k, input logic [13:0] a, input logic [13:0] b);
      c0 = {4{a}}; c1 = {4{b}}; in_valid = 1;
      repeat (k) begin
         n = 0;
         while (!irdy && n < 100) begin tick(1); n++; end
         tick(1);
      end
      in_valid = 0;
      n = 0;
      while (ovalid && n < 100) begin tick(1); n++; end
   endtask
   task tally_and_finish;
      if (fail_count == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      tally_and_finish;
   end
   initial begin
      rst;
      rd_reg(16'h0027, 8'h88);
      rd_reg(16'h0028, 8'h08);
      wr_reg(16'h0027, 8'h84);
      wr_reg(16'h0028, 8'h0c);
      rd_reg(16'h0027, 8'h84);
      rd_reg(16'h0028, 8'h0c);
      wr_reg(16'h0029, 8'h55);
      rd_reg(16'h0029, 8'h00);
      for (int h = 0; h < 2; h++) begin
         rst;
         cfg(4'h8, h[0], 0, 0, 16'h0000);
         push(6, 14'd100, 14'd100);
         chk(i_sink.q.size(), 3);
         foreach (i_sink.q[i]) chk(i_sink.q[i], {4{h ? 16'h0000 : 16'd400, 16'h0000}});
      end
      rst;
      cfg(4'h8, 1, 0, 1, 16'h0000);
      push(5, 14'h2000, 14'h2000);
      chk(i_sink.q.size(), 2);
      chk(flag, 4'hf);
      foreach (i_sink.q[i]) chk(i_sink.q[i] & {4{32'hffff0000}}, {4{32'h00010000}});
      for (int w = 0; w < 2; w++) begin
         rst;
         cfg(4'h3, 0, 0, 0, w ? 16'hc000 : 16'h4000);
         push(6, 14'd300, 14'd50);
         chk(i_sink.q.size(), 3);
         foreach (i_sink.q[i]) chk(i_sink.q[i], 128'h0);
      end
      rst;
      cfg(4'h8, 0, 0, 0, 16'h0000);
      cfg(4'h8, 0, 1, 0, 16'h0000);
      push(6, 14'd100, 14'd100);
      chk(i_sink.q.size(), 5);
      foreach (i_sink.q[i]) chk(i_sink.q[i], {2{32'h0, 16'd400, 16'd400}});
      rst;
      cfg(4'h8, 0, 0, 0, 16'h0000);
      stall = 1;
      in_valid = 1;
      n = 0;
      repeat (20) begin
         if (irdy) n++;
         tick(1);
      end
      chk(n, 11);
      chk(irdy, 0);
      in_valid = 0;
      stall = 0;
      n = 0;
      while (ovalid && n < 100) begin tick(1); n++; end
      chk(i_sink.q.size(), 8);
      rst;
      push(7, 14'd100, 14'd100);
      chk(i_sink.q.size(), 2);
      chk(i_sink.q[0], {4{16'h00c8, 16'hff38}});
      tally_and_finish;
   end
endmodule
`default_nettype wire
